// [flash_cmd_pkg.sv]
`default_nettype none
package flash_cmd_pkg;
   typedef enum logic [1:0] {LINES_1 = 2'b00, LINES_2 = 2'b01, LINES_4 = 2'b10} lines_t;
   typedef enum logic [1:0] {DIR_NONE = 2'b00, DIR_IN = 2'b01, DIR_OUT = 2'b10} dir_t;
   typedef enum logic [2:0] {
      PH_CMD = 3'b000, PH_ADDR = 3'b001, PH_DUMMY = 3'b010, PH_DATA = 3'b011,
      PH_IGNORE = 3'b100, PH_DONE = 3'b101, PH_IDLE = 3'b110
   } phase_t;
   typedef struct packed {
      logic       valid;
      logic [1:0] addrCyc;
      logic [1:0] dummyCyc;
      lines_t     addrLines;
      lines_t     dataLines;
      dir_t       dir;
      logic [1:0] inBytes;
   } cmd_info_t;

   localparam logic [7:0] OP_NOP = 8'h00, OP_RSTEN = 8'h66, OP_RST = 8'h99, OP_EQIO = 8'h38;
   localparam logic [7:0] OP_RSTQIO = 8'hff, OP_RDSR = 8'h05, OP_WRSR = 8'h01, OP_RDCR = 8'h35;
   localparam logic [7:0] OP_READ = 8'h03, OP_FAST_READ = 8'h0b, OP_QUAD_OUT_READ = 8'h6b;
   localparam logic [7:0] OP_QUAD_IO_READ = 8'heb, OP_DUAL_OUT_READ = 8'h3b;
   localparam logic [7:0] OP_DUAL_IO_READ = 8'hbb, OP_SET_BURST = 8'hc0;
   localparam logic [7:0] OP_WRAP_READ_QUAD = 8'h0c, OP_WRAP_READ_SPI = 8'hec;
   localparam logic [7:0] OP_JEDEC_ID = 8'h9f, OP_QUAD_ID = 8'haf, OP_DISCOVERY = 8'h5a;
   localparam logic [7:0] OP_WREN = 8'h06, OP_WRDI = 8'h04, OP_SECTOR_ERASE = 8'h20;
   localparam logic [7:0] OP_BLOCK_ERASE = 8'hd8, OP_CHIP_ERASE = 8'hc7, OP_PAGE_PROG = 8'h02;
   localparam logic [7:0] OP_QUAD_PAGE_PROG = 8'h32, OP_SUSPEND = 8'hb0, OP_RESUME = 8'h30;
   localparam logic [7:0] OP_RBPR = 8'h72, OP_WBPR = 8'h42, OP_LOCK_BP = 8'h8d;
   localparam logic [7:0] OP_NV_LOCK = 8'he8, OP_UNLOCK_BP = 8'h98;

   localparam int CFG_RECONF_BIT = 1;
   localparam int CFG_VOLATILITY_BIT = 3;
   localparam int CFG_PIN_EN_BIT = 7;
   localparam int STS_BUSY_LO_BIT = 0;
   localparam int STS_BUSY_HI_BIT = 7;
   localparam logic RECONF_RESET = 1'b0;
   localparam logic PIN_EN_RESET = 1'b0;
   localparam logic LOCK_SET_RESET = 1'b0;
   localparam logic [1:0] WRSR_CFG_INDEX = 2'h1;

   localparam int CLK_PERIOD_NS = 10;
   localparam int ENABLE_BIT_WRITE_TIME_NS = 5000;
   localparam int ENABLE_BIT_WRITE_CYCLES =
      (ENABLE_BIT_WRITE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int HOST_HALF_PERIOD = 4;

   // Opcode table per protocol mode
   function automatic cmd_info_t decode_cmd(input logic [7:0] op, input logic quad,
                                           input logic reconf);
      cmd_info_t c;
      logic      spi;
      logic      quadOk;
      logic      needReconf;
      c = '0;
      spi = 1'b0;
      quadOk = 1'b0;
      needReconf = 1'b0;
      c.addrLines = quad ? LINES_4 : LINES_1;
      c.dataLines = quad ? LINES_4 : LINES_1;
      case (op)
         OP_NOP, OP_RSTEN, OP_RST, OP_RSTQIO, OP_WREN, OP_WRDI, OP_CHIP_ERASE, OP_SUSPEND,
         OP_RESUME, OP_LOCK_BP, OP_UNLOCK_BP: begin
            spi = 1'b1;
            quadOk = 1'b1;
         end
         OP_EQIO: spi = 1'b1;
         OP_RDSR, OP_RDCR, OP_RBPR: begin
            spi = 1'b1;
            quadOk = 1'b1;
            c.dir = DIR_OUT;
            c.dummyCyc = quad ? 2'd1 : 2'd0;
         end
         OP_WRSR, OP_WBPR, OP_NV_LOCK, OP_SET_BURST: begin
            spi = 1'b1;
            quadOk = 1'b1;
            c.dir = DIR_IN;
            c.inBytes = (op == OP_WRSR) ? 2'd2 : (op == OP_SET_BURST) ? 2'd1 : 2'd0;
         end
         OP_READ, OP_FAST_READ, OP_DISCOVERY, OP_DUAL_OUT_READ, OP_QUAD_OUT_READ,
         OP_DUAL_IO_READ, OP_QUAD_IO_READ, OP_WRAP_READ_SPI, OP_WRAP_READ_QUAD: begin
            spi = (op != OP_WRAP_READ_QUAD);
            quadOk = (op == OP_FAST_READ) || (op == OP_WRAP_READ_QUAD);
            needReconf = (op == OP_QUAD_OUT_READ) || (op == OP_QUAD_IO_READ) ||
                         (op == OP_WRAP_READ_SPI);
            c.dir = DIR_OUT;
            c.addrCyc = 2'd3;
            c.dummyCyc = (op == OP_READ) ? 2'd0 : 2'd1;
            if (quad || op == OP_QUAD_IO_READ || op == OP_WRAP_READ_SPI || op == OP_WRAP_READ_QUAD)
               c.dummyCyc = 2'd3;
            if (!quad && (needReconf || op == OP_DUAL_OUT_READ || op == OP_DUAL_IO_READ))
               c.dataLines = (op == OP_DUAL_OUT_READ || op == OP_DUAL_IO_READ) ? LINES_2 : LINES_4;
            if (!quad && (op == OP_QUAD_IO_READ || op == OP_WRAP_READ_SPI))
               c.addrLines = LINES_4;
            if (op == OP_DUAL_IO_READ)
               c.addrLines = LINES_2;
         end
         OP_JEDEC_ID, OP_QUAD_ID: begin
            spi = (op == OP_JEDEC_ID);
            quadOk = (op == OP_QUAD_ID);
            c.dir = DIR_OUT;
            c.dummyCyc = quad ? 2'd1 : 2'd0;
         end
         OP_SECTOR_ERASE, OP_BLOCK_ERASE, OP_PAGE_PROG, OP_QUAD_PAGE_PROG: begin
            spi = 1'b1;
            quadOk = (op != OP_QUAD_PAGE_PROG);
            needReconf = (op == OP_QUAD_PAGE_PROG);
            c.addrCyc = 2'd3;
            c.dir = (op == OP_PAGE_PROG || op == OP_QUAD_PAGE_PROG) ? DIR_IN : DIR_NONE;
            if (op == OP_QUAD_PAGE_PROG)
               c.dataLines = LINES_4;
         end
         default: ;
      endcase
      c.valid = (quad ? quadOk : spi) && (!needReconf || reconf);
      return c;
   endfunction

   function automatic phase_t next_phase(input cmd_info_t c, input phase_t p);
      if (p == PH_CMD && c.addrCyc != 2'd0)
         return PH_ADDR;
      if ((p == PH_CMD || p == PH_ADDR) && c.dummyCyc != 2'd0)
         return PH_DUMMY;
      if (c.dir != DIR_NONE)
         return PH_DATA;
      return PH_DONE;
   endfunction

   function automatic lines_t phase_lines(input cmd_info_t c, input phase_t p, input logic quad);
      if (p == PH_CMD)
         return quad ? LINES_4 : LINES_1;
      return (p == PH_DATA) ? c.dataLines : c.addrLines;
   endfunction

   function automatic logic [3:0] byte_clocks(input lines_t l);
      return (l == LINES_4) ? 4'd2 : (l == LINES_2) ? 4'd4 : 4'd8;
   endfunction

   // Single-line traffic uses pin 0 from host, pin 1 from device
   function automatic logic [3:0] emit(input lines_t l, input logic [7:0] b, input logic sel);
      if (l == LINES_4)
         return b[7:4];
      if (l == LINES_2)
         return {2'b00, b[7:6]};
      return sel ? {2'b00, b[7], 1'b0} : {3'b000, b[7]};
   endfunction

   function automatic logic [7:0] shl(input lines_t l, input logic [7:0] b);
      return (l == LINES_4) ? {b[3:0], 4'h0} : (l == LINES_2) ? {b[5:0], 2'h0} : {b[6:0], 1'b0};
   endfunction

   function automatic logic [3:0] oe_mask(input lines_t l, input logic sel);
      return (l == LINES_4) ? 4'hf : (l == LINES_2) ? 4'h3 : (sel ? 4'h2 : 4'h1);
   endfunction

   function automatic logic [7:0] shift_in(input lines_t l, input logic [7:0] s,
                                          input logic [3:0] pins, input logic sel);
      if (l == LINES_4)
         return {s[3:0], pins};
      if (l == LINES_2)
         return {s[5:0], pins[1:0]};
      return {s[6:0], sel ? pins[1] : pins[0]};
   endfunction
endpackage
`default_nettype wire

// [flash_link_if.sv]
`timescale 1ns/1ns
`default_nettype none
interface flash_link_if;
   logic       sck;
   logic       csN;
   logic       wpN;
   logic [3:0] hostOut;
   logic [3:0] hostOe;
   logic [3:0] devOut;
   logic [3:0] devOe;
   logic [3:0] sio;

   // Pin level with pull-up when nobody drives
   always_comb begin
      for (int i = 0; i < 4; i++) begin
         sio[i] = hostOe[i] ? hostOut[i] : (devOe[i] ? devOut[i] : 1'b1);
      end
   end

   modport host (output sck, output csN, output wpN, output hostOut, output hostOe, input sio);
   modport dev (input sck, input csN, input wpN, input sio, output devOut, output devOe);
endinterface
`default_nettype wire

// [flash_cmd_device.sv]
`timescale 1ns/1ns
`default_nettype none
module flash_cmd_device
   import flash_cmd_pkg::*;
(
   flash_link_if.dev link,
   input  wire logic clk,
   input  wire logic nrst,
   output logic      busy,
   output logic      hwProtected,
   output logic      lockVolatile,
   output logic      quadMode
);
   typedef struct packed {
      phase_t     phase;
      logic [7:0] op;
      cmd_info_t  info;
      logic [3:0] byteClk;
      logic [1:0] cyc;
      logic [1:0] byteCnt;
      logic [7:0] shiftIn;
      logic [23:0] addr;
      logic [7:0] outShift;
      logic [3:0] sioOut;
      logic [3:0] sioOe;
   } frame_t;

   typedef struct packed {
      logic       quad;
      logic       reconf;
      logic       pinEn;
      logic       lockSet;
      logic       pinEnTog;
      logic [1:0] wpS;
      logic [1:0] busyS;
   } keep_t;

   typedef struct packed {
      logic [2:0]  togS;
      logic [1:0]  pinEnS;
      logic [1:0]  lockS;
      logic [1:0]  quadS;
      logic [1:0]  wpS;
      logic [11:0] cnt;
      logic        busy;
   } user_t;

   frame_t     f;
   frame_t     next_f;
   keep_t      k;
   keep_t      next_k;
   user_t      u;
   user_t      next_u;
   logic       frameRstN;
   logic       cmdDone;
   logic       byteDone;
   logic [7:0] byteVal;
   logic       hwProt;
   logic [7:0] cfgByte;
   logic [7:0] stsByte;

   ////////////////////////////////////////////////////////////////////////////
   // Frame sequencer on the link clock
   assign frameRstN = nrst & ~link.csN;
   assign hwProt = ~k.wpS[1] & k.pinEn;
   always_comb begin
      cfgByte = 8'h00;
      cfgByte[CFG_RECONF_BIT] = k.reconf;
      cfgByte[CFG_VOLATILITY_BIT] = ~k.lockSet;
      cfgByte[CFG_PIN_EN_BIT] = k.pinEn;
      stsByte = 8'h00;
      stsByte[STS_BUSY_LO_BIT] = k.busyS[1];
      stsByte[STS_BUSY_HI_BIT] = k.busyS[1];
   end

   always_comb begin
      lines_t     ln;
      logic       byteEnd;
      logic [7:0] rx;
      logic [7:0] b;
      ln = phase_lines(f.info, f.phase, k.quad);
      byteEnd = (f.byteClk + 4'd1) == byte_clocks(ln);
      rx = shift_in(ln, f.shiftIn, link.sio, 1'b0);
      b = 8'h00;
      next_f = f;
      cmdDone = 1'b0;
      byteDone = 1'b0;
      byteVal = rx;
      next_f.shiftIn = rx;
      next_f.byteClk = byteEnd ? 4'd0 : f.byteClk + 4'd1;
      case (f.phase)
         PH_CMD: begin
            if (byteEnd) begin
               next_f.op = rx;
               next_f.info = decode_cmd(rx, k.quad, k.reconf);
               cmdDone = next_f.info.valid;
               next_f.phase = next_f.info.valid ? next_phase(next_f.info, PH_CMD) : PH_IGNORE;
            end
         end
         PH_ADDR: begin
            if (byteEnd) begin
               next_f.addr = {f.addr[15:0], rx};
               next_f.cyc = f.cyc + 2'd1;
               if (f.cyc + 2'd1 == f.info.addrCyc) begin
                  next_f.cyc = 2'd0;
                  next_f.phase = next_phase(f.info, PH_ADDR);
               end
            end
         end
         PH_DUMMY: begin
            if (byteEnd) begin
               next_f.cyc = f.cyc + 2'd1;
               if (f.cyc + 2'd1 == f.info.dummyCyc) begin
                  next_f.cyc = 2'd0;
                  next_f.phase = next_phase(f.info, PH_DUMMY);
               end
            end
         end
         PH_DATA: begin
            if (f.info.dir == DIR_IN && byteEnd) begin
               byteDone = 1'b1;
               next_f.byteCnt = f.byteCnt + 2'd1;
               if (f.info.inBytes != 2'd0 && f.byteCnt + 2'd1 == f.info.inBytes)
                  next_f.phase = PH_DONE;
            end
            if (f.info.dir == DIR_OUT && byteEnd)
               next_f.addr = f.addr + 24'd1;
         end
         default: ;
      endcase
      // Read data: registers, else a running address pattern
      if (next_f.phase == PH_DATA && next_f.info.dir == DIR_OUT) begin
         if (f.phase != PH_DATA || byteEnd) begin
            if (next_f.op == OP_RDSR)
               b = stsByte;
            else if (next_f.op == OP_RDCR)
               b = cfgByte;
            else
               b = next_f.addr[7:0];
            next_f.sioOut = emit(next_f.info.dataLines, b, 1'b1);
            next_f.outShift = shl(next_f.info.dataLines, b);
            next_f.sioOe = oe_mask(next_f.info.dataLines, 1'b1);
         end else begin
            next_f.sioOut = emit(ln, f.outShift, 1'b1);
            next_f.outShift = shl(ln, f.outShift);
         end
      end else begin
         next_f.sioOe = 4'h0;
      end
   end

   always_ff @(posedge link.sck or negedge frameRstN) begin
      if (!frameRstN) begin
         f <= '0;
      end else begin
         f <= next_f;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Persistent mode and protection bits
   always_comb begin
      next_k = k;
      next_k.wpS = {k.wpS[0], link.wpN};
      next_k.busyS = {k.busyS[0], u.busy};
      if (cmdDone && next_f.op == OP_EQIO)
         next_k.quad = 1'b1;
      if (cmdDone && next_f.op == OP_RSTQIO)
         next_k.quad = 1'b0;
      if (byteDone && f.op == OP_WRSR && f.byteCnt == WRSR_CFG_INDEX && !hwProt) begin
         next_k.reconf = byteVal[CFG_RECONF_BIT];
         next_k.pinEn = byteVal[CFG_PIN_EN_BIT];
         next_k.pinEnTog = ~k.pinEnTog;
      end
      if (byteDone && f.op == OP_NV_LOCK && byteVal != 8'h00)
         next_k.lockSet = 1'b1;
   end

   // Power-on values stand for the factory state of the nonvolatile bits
   always_ff @(posedge link.sck or negedge nrst) begin
      if (!nrst) begin
         k <= '{quad: 1'b0, reconf: RECONF_RESET, pinEn: PIN_EN_RESET, lockSet: LOCK_SET_RESET,
                pinEnTog: 1'b0, wpS: 2'b11, busyS: 2'b00};
      end else begin
         k <= next_k;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Self-timed enable-bit write and status on the system clock
   always_comb begin
      next_u = u;
      next_u.togS = {u.togS[1:0], k.pinEnTog};
      next_u.pinEnS = {u.pinEnS[0], k.pinEn};
      next_u.lockS = {u.lockS[0], k.lockSet};
      next_u.quadS = {u.quadS[0], k.quad};
      next_u.wpS = {u.wpS[0], link.wpN};
      if (u.togS[2] != u.togS[1]) begin
         next_u.busy = 1'b1;
         next_u.cnt = 12'(ENABLE_BIT_WRITE_CYCLES - 1);
      end else if (u.busy) begin
         if (u.cnt == 12'h000)
            next_u.busy = 1'b0;
         else
            next_u.cnt = u.cnt - 12'h001;
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         u <= '{togS: 3'b000, pinEnS: 2'b00, lockS: 2'b00, quadS: 2'b00, wpS: 2'b11,
                cnt: 12'h000, busy: 1'b0};
      end else begin
         u <= next_u;
      end
   end

   assign busy = u.busy;
   assign hwProtected = ~u.wpS[1] & u.pinEnS[1];
   assign lockVolatile = ~u.lockS[1];
   assign quadMode = u.quadS[1];
   assign link.devOut = f.sioOut;
   assign link.devOe = f.sioOe;
endmodule
`default_nettype wire

// [flash_cmd_host.sv]
`timescale 1ns/1ns
`default_nettype none
module flash_cmd_host
   import flash_cmd_pkg::*;
(
   flash_link_if.host link,
   input  wire logic        clk,
   input  wire logic        nrst,
   input  wire logic        start,
   input  wire logic [7:0]  startOp,
   input  wire logic [23:0] startAddr,
   input  wire logic [15:0] startData,
   input  wire logic [7:0]  startLen,
   input  wire logic        wpLevel,
   output logic             idle,
   output logic [7:0]       rdData,
   output logic             rdValid,
   output logic             done,
   output logic             quadMode
);
   typedef struct packed {
      phase_t      phase;
      logic [1:0]  div;
      logic        sck;
      logic        csN;
      logic        wpN;
      logic [7:0]  op;
      cmd_info_t   info;
      logic [23:0] addr;
      logic [15:0] wdata;
      logic [7:0]  len;
      logic [7:0]  byteCnt;
      logic [3:0]  byteClk;
      logic [1:0]  cyc;
      logic [7:0]  txShift;
      logic [7:0]  rxShift;
      logic [3:0]  sioOut;
      logic [3:0]  sioOe;
      logic [7:0]  sioS;
      logic        quad;
      logic [7:0]  rdData;
      logic        rdValid;
      logic        done;
   } host_t;

   host_t h;
   host_t next_h;

   ////////////////////////////////////////////////////////////////////////////
   // Frame generator with divided link clock
   always_comb begin
      lines_t     ln;
      logic       rise;
      logic       fall;
      logic       byteEnd;
      logic [7:0] rx;
      ln = phase_lines(h.info, h.phase, h.quad);
      rise = (h.div == 2'(HOST_HALF_PERIOD - 1)) && !h.sck;
      fall = (h.div == 2'(HOST_HALF_PERIOD - 1)) && h.sck;
      byteEnd = (h.byteClk + 4'd1) == byte_clocks(ln);
      rx = shift_in(ln, h.rxShift, h.sioS[7:4], 1'b1);
      next_h = h;
      next_h.rdValid = 1'b0;
      next_h.done = 1'b0;
      next_h.wpN = wpLevel;
      next_h.sioS = {h.sioS[3:0], link.sio};
      next_h.div = (h.phase == PH_IDLE) ? 2'd0 : h.div + 2'd1;
      if (h.phase != PH_IDLE && (rise || fall))
         next_h.sck = ~h.sck;
      case (h.phase)
         PH_IDLE: begin
            if (start) begin
               next_h.csN = 1'b0;
               next_h.op = startOp;
               next_h.info = decode_cmd(startOp, h.quad, 1'b1);
               next_h.addr = startAddr;
               next_h.wdata = startData;
               next_h.len = (startLen == 8'h00) ? 8'h01 : startLen;
               next_h.byteCnt = 8'h00;
               next_h.byteClk = 4'd0;
               next_h.cyc = 2'd0;
               next_h.sioOut = emit(h.quad ? LINES_4 : LINES_1, startOp, 1'b0);
               next_h.sioOe = oe_mask(h.quad ? LINES_4 : LINES_1, 1'b0);
               next_h.txShift = shl(h.quad ? LINES_4 : LINES_1, startOp);
               next_h.phase = PH_CMD;
            end
         end
         PH_DONE: begin
            if (fall) begin
               next_h.csN = 1'b1;
               next_h.sioOe = 4'h0;
               next_h.done = 1'b1;
               next_h.phase = PH_IDLE;
               if (h.info.valid && h.op == OP_EQIO)
                  next_h.quad = 1'b1;
               if (h.info.valid && h.op == OP_RSTQIO)
                  next_h.quad = 1'b0;
            end
         end
         default: begin
            if (fall) begin
               if (h.phase == PH_DUMMY || (h.phase == PH_DATA && h.info.dir == DIR_OUT)) begin
                  next_h.sioOe = 4'h0;
               end else begin
                  next_h.sioOut = emit(ln, h.txShift, 1'b0);
                  next_h.sioOe = oe_mask(ln, 1'b0);
                  next_h.txShift = shl(ln, h.txShift);
               end
            end
            if (rise) begin
               next_h.rxShift = rx;
               next_h.byteClk = byteEnd ? 4'd0 : h.byteClk + 4'd1;
               if (byteEnd) begin
                  next_h.cyc = h.cyc + 2'd1;
                  case (h.phase)
                     PH_CMD: begin
                        next_h.cyc = 2'd0;
                        next_h.phase = h.info.valid ? next_phase(h.info, PH_CMD) : PH_DONE;
                        next_h.txShift = h.addr[23:16];
                     end
                     PH_ADDR: begin
                        next_h.addr = {h.addr[15:0], 8'h00};
                        next_h.txShift = h.addr[15:8];
                        if (h.cyc + 2'd1 == h.info.addrCyc) begin
                           next_h.cyc = 2'd0;
                           next_h.phase = next_phase(h.info, PH_ADDR);
                        end
                     end
                     PH_DUMMY: begin
                        if (h.cyc + 2'd1 == h.info.dummyCyc) begin
                           next_h.cyc = 2'd0;
                           next_h.phase = next_phase(h.info, PH_DUMMY);
                        end
                     end
                     default: begin
                        next_h.byteCnt = h.byteCnt + 8'h01;
                        next_h.txShift = h.byteCnt[0] ? h.wdata[15:8] : h.wdata[7:0];
                        if (h.info.dir == DIR_OUT) begin
                           next_h.rdData = rx;
                           next_h.rdValid = 1'b1;
                        end
                        if (h.byteCnt + 8'h01 == h.len)
                           next_h.phase = PH_DONE;
                     end
                  endcase
                  if (next_h.phase == PH_DATA && h.phase != PH_DATA)
                     next_h.txShift = h.wdata[15:8];
               end
            end
         end
      endcase
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         h <= '{phase: PH_IDLE, csN: 1'b1, wpN: 1'b1, sioS: 8'hff, default: '0};
      end else begin
         h <= next_h;
      end
   end

   assign link.sck = h.sck;
   assign link.csN = h.csN;
   assign link.wpN = h.wpN;
   assign link.hostOut = h.sioOut;
   assign link.hostOe = h.sioOe;
   assign idle = (h.phase == PH_IDLE);
   assign rdData = h.rdData;
   assign rdValid = h.rdValid;
   assign done = h.done;
   assign quadMode = h.quad;
endmodule
`default_nettype wire

// [flash_link_props.sv]
`timescale 1ns/1ns
`default_nettype none
module flash_link_props (
   input wire logic       sck,
   input wire logic       csN,
   input wire logic       nrst,
   input wire logic [3:0] sio,
   input wire logic [3:0] devOe
);
   logic [7:0] cnt;
   logic [7:0] op;
   always_ff @(posedge sck or posedge csN) begin
      if (csN) begin
         cnt <= 8'h00;
         op  <= 8'h00;
      end else begin
         cnt <= cnt + 8'h01;
         op  <= (cnt < 8'h08) ? {op[6:0], sio[0]} : op;
      end
   end
   ////////////////////////
   default clocking @(posedge sck); endclocking
   default disable iff (csN || !nrst);
   a_cmd_quiet: assert property (cnt < 8'h08 |-> !devOe)
      else $error("drive during opcode");
   a_fast_gap: assert property (op == 8'h0b && cnt > 8'h07 && cnt < 8'h28 |-> !devOe)
      else $error("early read drive");
   a_fast_data: assert property (op == 8'h0b && cnt == 8'h28 |=> (devOe == 4'h2) [*4])
      else $error("fast read lines");
   a_dual_data: assert property (op == 8'h3b && cnt == 8'h29 |-> devOe == 4'h3)
      else $error("dual read lines");
   a_param_data: assert property (op == 8'h5a && cnt == 8'h29 |-> devOe == 4'h2)
      else $error("table read lines");
   a_erase_quiet: assert property ((op == 8'h20 || op == 8'hd8) && cnt > 8'h07 |-> !devOe)
      else $error("erase drives");
   a_refused_quiet: assert property ((op == 8'h0c || op == 8'h11) && cnt > 8'h07 |-> !devOe)
      else $error("refused op drives");
   a_wrap_data: assert property (op == 8'hec && cnt == 8'h14 |-> devOe == 4'hf)
      else $error("wrap read lines");
   cover property (op == 8'h0b && cnt == 8'h29);
   cover property (op == 8'hec && cnt == 8'h15);
   cover property (op == 8'h11 && cnt == 8'h08);
endmodule
`default_nettype wire

// [tb_serial_flash_command_decode.sv]
`timescale 1ns/1ns
`default_nettype none
module tb_serial_flash_command_decode
   import flash_cmd_pkg::*;
;
   logic        clk, nrst, start, wpLevel, done, busy, hwProtected, lockVolatile;
   logic        idle, rdValid, devQuad, hostQuad;
   logic [7:0]  startOp, startLen, rdData;
   logic [15:0] startData;
   logic [23:0] startAddr;
   int          fails, checks, busyLen, pulses, i;
   flash_link_if link ();
   flash_cmd_host u_flash_cmd_host (.link(link), .clk(clk), .nrst(nrst), .start(start),
      .startOp(startOp), .startAddr(startAddr), .startData(startData), .startLen(startLen),
      .wpLevel(wpLevel), .idle(idle), .rdData(rdData), .rdValid(rdValid), .done(done),
      .quadMode(hostQuad));
   flash_cmd_device u_flash_cmd_device (.link(link), .clk(clk), .nrst(nrst), .busy(busy),
      .hwProtected(hwProtected), .lockVolatile(lockVolatile), .quadMode(devQuad));
   flash_link_props u_flash_link_props (.sck(link.sck), .csN(link.csN), .nrst(nrst),
      .sio(link.sio), .devOe(link.devOe));
   always @(posedge clk) busyLen <= busy ? busyLen + 1 : 0;
   always @(posedge clk) pulses <= rdValid ? pulses + 1 : pulses;
   ////////////////////////
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      checks++;
      if (seen !== exp) begin
         fails++;
         $display("Error t=%0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic stop_test;
      $display("checks %0d fails %0d", checks, fails);
      if (fails == 0 && checks > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask
   task automatic cmd(input logic [7:0] op, input logic [23:0] a, input logic [15:0] d);
      @(posedge clk);
      start     <= 1'b1;
      startOp   <= op;
      startAddr <= a;
      startData <= d;
      startLen  <= 8'h02;
      @(posedge clk);
      start <= 1'b0;
      for (i = 0; i < 3000 && done !== 1'b1; i++) @(negedge clk);
      limit(3000);
      check(idle, 16'h1);
   endtask
   task automatic limit(input int n);
      if (i >= n) begin
         fails++;
         stop_test();
      end
   endtask
   ////////////////////////
   task automatic t_reset;
      repeat (4) @(negedge clk);
      check({busy, hwProtected, lockVolatile}, 16'h1);
   endtask
   task automatic t_reads;
      logic [7:0] rop[4] = '{8'h0b, 8'h3b, 8'h5a, 8'h6b};
      int         base;
      for (int k = 0; k < 4; k++) begin
         base = pulses;
         cmd(rop[k], {16'h0, rop[k]}, 16'h0);
         check(rdData, k == 3 ? 16'hff : rop[k] + 16'h1);
         check(16'(pulses - base), 16'h2);
      end
      cmd(8'h0c, 24'h0, 16'h0);
      cmd(8'h11, 24'h0, 16'h0);
      cmd(8'h0b, 24'h000060, 16'h0);
      check(rdData, 16'h61);
   endtask
   task automatic t_quad;
      cmd(8'h38, 24'h0, 16'h0);
      check({devQuad, hostQuad}, 16'h3);
      cmd(8'h0c, 24'h000070, 16'h0);
      check(rdData, 16'h71);
      cmd(8'h0b, 24'h000030, 16'h0);
      check(rdData, 16'h31);
      cmd(8'hff, 24'h0, 16'h0);
      check({devQuad, hostQuad}, 16'h0);
   endtask
   task automatic t_protect;
      cmd(8'h01, 24'h0, 16'h0082);
      for (i = 0; i < 8 && busy !== 1'b1; i++) @(negedge clk);
      limit(8);
      for (i = 0; i < 1000 && busy === 1'b1; i++) @(negedge clk);
      limit(1000);
      check(16'(busyLen), 16'(ENABLE_BIT_WRITE_CYCLES));
      for (i = 0; i < 8 && hwProtected !== 1'b1; i++) @(negedge clk);
      limit(8);
      check(hwProtected, 16'h1);
      cmd(8'h01, 24'h0, 16'h0000);
      repeat (8) @(negedge clk);
      check({busy, hwProtected}, 16'h1);
      cmd(8'h20, 24'h001000, 16'h0);
      cmd(8'hd8, 24'h010000, 16'h0);
      cmd(8'he8, 24'h0, 16'h0101);
      for (i = 0; i < 8 && lockVolatile !== 1'b0; i++) @(negedge clk);
      limit(8);
      check(lockVolatile, 16'h0);
      @(posedge clk);
      wpLevel <= 1'b1;
      for (i = 0; i < 8 && hwProtected !== 1'b0; i++) @(negedge clk);
      limit(8);
      check(hwProtected, 16'h0);
      cmd(8'h6b, 24'h000040, 16'h0);
      check(rdData, 16'h41);
      cmd(8'hec, 24'h000050, 16'h0);
      check({lockVolatile, rdData}, 16'h51);
   endtask
   ////////////////////////
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   initial begin
      nrst      = 1'b0;
      start     = 1'b0;
      startOp   = 8'h00;
      startAddr = 24'h0;
      startData = 16'h0;
      startLen  = 8'h00;
      wpLevel   = 1'b0;
      repeat (10) @(posedge clk);
      nrst <= 1'b1;
      t_reset();
      t_reads();
      t_quad();
      t_protect();
      stop_test();
   end
endmodule
`default_nettype wire
